// File: lfm_defs.svh
// Purpose: constants for the led fault status and mask block
// Assumes: byte-wide registers reached through a plain register port
// Notes:   offsets, field positions, reset values per variant
//
// Function
// [RULE1] fault pin driven by a status flag only when its mask bit is zero
// [RULE2] mask bits: 7 in overcurrent, 6 in overvolt, 5 check, 4 alert, 3 led, 2 out, 1 thermal
// [RULE3] device status is read-only, same bit layout, bit 0 reserved
// [RULE4] device status flags latch; cleared only by clear-flags write or reset
// [RULE5] led fault flag set when channel status is nonzero, pin unless masked
// [RULE6] channel check flag set when startup status nonzero after check
// [RULE7] status bit 4 reports overtemperature early alert as a warning
// [RULE8] channel status: shorts ch4..1 in bits 7..4, opens in bits 3..0
// [RULE9] short flag on excessive drop, open flag when current not regulated
// [RULE10] disabled channels excluded, status bits zero, config never modified
// [RULE11] each detection occurrence overwrites channel status with latest results
// [RULE12] clear-flags or reset clears channel status and releases pin
// [RULE13] startup status: resistor fault 7, adjacent shorts 6..4, ground 3..0
// [RULE14] startup status records results of startup fault tests
// [RULE15] clear-flags or reset clears startup status and releases pin
// [RULE16] register variant stays in standby until host sets device enable
// [RULE17] register variant channel configuration resets to 0Fh
// [RULE18] standalone variant resets with device enable set
// [RULE19] standalone variant channel configuration resets to 7Fh
// [RULE20] with auto-disconnect, confirmed open channel switched off
// [RULE21] standalone variant fault pin is unlatched
// [RULE22] standalone variant mask resets to 10h
// [RULE23] latch selector: zero real-time pin, one pin holds asserted
// [RULE24] auto-disconnect bit one switches off open channels, zero leaves them
// [RULE25] clear-flags is a write-one pulse reading back zero
`ifndef LFM_DEFS_SVH
`define LFM_DEFS_SVH
`define LFM_ADDR_DEV_ENABLE   8'h00
`define LFM_ADDR_DEV_CONFIG   8'h01
`define LFM_ADDR_CHAN_CONFIG  8'h11
`define LFM_ADDR_FAULT_MGMT   8'h15
`define LFM_ADDR_PIN_MASK     8'h16
`define LFM_ADDR_DEV_STATUS   8'h17
`define LFM_ADDR_CHAN_STATUS  8'h18
`define LFM_ADDR_START_STATUS 8'h19
`define LFM_BIT_IN_OVERCUR    7
`define LFM_BIT_IN_OVERVOLT   6
`define LFM_BIT_CHAN_CHECK    5
`define LFM_BIT_OVERTEMP      4
`define LFM_BIT_LED_FAULT     3
`define LFM_BIT_OUT_OVERVOLT  2
`define LFM_BIT_THERMAL       1
`define LFM_BIT_DEV_ENABLE    0
`define LFM_BIT_CLEAR_FLAGS   0
`define LFM_BIT_PIN_LATCH     4
`define LFM_BIT_OPEN_AUTO_OFF 3
`define LFM_STA_MASK          8'hFE
`define LFM_CHAN_CFG_WMASK    8'h7F
`define LFM_CHAN_CFG_RST_A    8'h0F
`define LFM_CHAN_CFG_RST_B    8'h7F
`define LFM_PIN_MASK_RST_A    8'h00
`define LFM_PIN_MASK_RST_B    8'h10
`define LFM_FAULT_MGMT_RST_A  8'h01
`define LFM_FAULT_MGMT_RST_B  8'h69
`define LFM_ZERO8        8'h00
`endif

// File: lfm_pkg.sv
// Purpose: types for the led fault status and mask block
// Assumes: nothing beyond the defs header
// Notes:   sequencer state type
package lfm_pkg;
   typedef enum logic [2:0] {
      LFM_ST_STBY = 3'h1,
      LFM_ST_CHK  = 3'h2,
      LFM_ST_RUN  = 3'h4
   } lfm_state_t;
endpackage

// File: lfm_chan_mon.sv
// Purpose: one channel's short and open detection and auto-disconnect
// Assumes: detect_in marks one detection occurrence
// Notes:   disabled channel reports zero
`timescale 1ns/1ps
module lfm_chan_mon (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic clr_in,
   input  wire logic detect_in,
   input  wire logic enable_in,
   input  wire logic auto_off_in,
   input  wire logic drop_in,
   input  wire logic noreg_in,
   output logic      short_out,
   output logic      open_out,
   output logic      off_out
);
   logic short_q;
   logic open_q;
   logic off_q;
   logic live;
   assign live = enable_in & ~off_q;
   assign short_out = short_q;
   assign open_out = open_q;
   assign off_out = off_q;
   // overwrite on each detection; disabled channel forced low
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         short_q <= 1'b0;
         open_q  <= 1'b0;
         off_q   <= 1'b0;
      end else begin
         if (detect_in) begin
            short_q <= live & drop_in;  // RULE9 RULE11
            open_q  <= live & noreg_in; // RULE9 RULE11
         end else if (clr_in || !enable_in) begin
            short_q <= 1'b0;            // RULE10 RULE12
            open_q  <= 1'b0;
         end
         // confirmed open switches the channel off until the channel is disabled or auto-off is cleared
         if (!enable_in || !auto_off_in)
            off_q <= 1'b0;              // RULE24
         else if (detect_in && live && noreg_in)
            off_q <= 1'b1;              // RULE20
      end
   end
endmodule

// File: lfm_flag.sv
// Purpose: one sticky status flag, set wins over clear
// Assumes: clr_in is a one-cycle pulse
// Notes:   used for device status bits 7..1
`timescale 1ns/1ps
module lfm_flag (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic set_in,
   input  wire logic clr_in,
   output logic      flag_out
);
   logic flag_q;
   assign flag_out = flag_q;
   // latched until clear; simultaneous event keeps the flag
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         flag_q <= 1'b0;
      else if (set_in)
         flag_q <= 1'b1;   // RULE4
      else if (clr_in)
         flag_q <= 1'b0;   // RULE4
   end
endmodule

// File: lfm_top.sv
// Purpose: fault status, channel status, startup check and fault pin logic
// Assumes: register port single cycle; detector inputs synchronous
// Notes:   VARIANT_B selects standalone reset defaults
`include "lfm_defs.svh"
`timescale 1ns/1ps
module lfm_top #(
   parameter bit VARIANT_B = 1'b0,
   parameter int NCH       = 4
) (
   input  wire logic       MCLK_IN,
   input  wire logic       NRST_IN,
   input  wire logic       REG_WR_IN,
   input  wire logic       REG_RD_IN,
   input  wire logic [7:0] REG_ADDR_IN,
   input  wire logic [7:0] REG_WDATA_IN,
   input  wire logic       IN_OVERCUR_DET_IN,
   input  wire logic       IN_OVERVOLT_DET_IN,
   input  wire logic       OVERTEMP_DET_IN,
   input  wire logic       OUT_OVERVOLT_DET_IN,
   input  wire logic       THERMAL_DET_IN,
   input  wire logic       CH_DETECT_IN,
   input  wire logic [3:0] CH_DROP_IN,
   input  wire logic [3:0] CH_NOREG_IN,
   input  wire logic [7:0] INIT_RESULT_IN,
   output logic [7:0]      REG_RDATA_OUT,
   output logic            FAULT_OUT,
   output logic [3:0]      CH_ON_OUT,
   output logic            RUN_OUT
);
   initial begin
      if (NCH != 4) $error("lfm_top supports exactly four channels");
   end

   logic [7:0] mask_q;
   logic [7:0] chan_cfg_q;
   logic [7:0] fault_mgmt_q;
   logic       dev_enable_q;
   logic [7:0] start_sta_q;
   logic [7:0] rdata_q;
   logic       fault_q;
   logic [3:0] chon_q;
   lfm_pkg::lfm_state_t state_q;
   lfm_pkg::lfm_state_t state_d;

   // decode
   wire wr_mask  = REG_WR_IN && (REG_ADDR_IN == `LFM_ADDR_PIN_MASK);
   wire wr_ccfg  = REG_WR_IN && (REG_ADDR_IN == `LFM_ADDR_CHAN_CONFIG);
   wire wr_fmgmt = REG_WR_IN && (REG_ADDR_IN == `LFM_ADDR_FAULT_MGMT);
   wire wr_enab  = REG_WR_IN && (REG_ADDR_IN == `LFM_ADDR_DEV_ENABLE);
   // clear pulse, never stored so it reads zero
   wire clr = REG_WR_IN && (REG_ADDR_IN == `LFM_ADDR_DEV_CONFIG)
              && REG_WDATA_IN[`LFM_BIT_CLEAR_FLAGS]; // RULE25
   wire check_done = (state_q == lfm_pkg::LFM_ST_CHK);

   logic [3:0] short_flags;
   logic [3:0] open_flags;
   logic [3:0] auto_off;
   wire  [7:0] chan_status = {short_flags, open_flags}; // RULE8

   // one monitor per channel
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_ch
         lfm_chan_mon u_mon (
            .clk         (MCLK_IN),
            .rst_n       (NRST_IN),
            .clr_in      (clr),
            .detect_in   (CH_DETECT_IN && RUN_OUT),
            .enable_in   (chan_cfg_q[g]),
            .auto_off_in (fault_mgmt_q[`LFM_BIT_OPEN_AUTO_OFF]),
            .drop_in     (CH_DROP_IN[g]),
            .noreg_in    (CH_NOREG_IN[g]),
            .short_out   (short_flags[g]),
            .open_out    (open_flags[g]),
            .off_out     (auto_off[g])
         );
      end
   endgenerate

   // live causes of each device status flag
   wire [7:0] cause;
   // derived causes drop in the clear cycle, as their source registers clear too;
   // otherwise set-wins would keep the flag alive past the clear
   assign cause[`LFM_BIT_IN_OVERCUR]   = IN_OVERCUR_DET_IN;
   assign cause[`LFM_BIT_IN_OVERVOLT]  = IN_OVERVOLT_DET_IN;
   assign cause[`LFM_BIT_CHAN_CHECK]   = (start_sta_q != `LFM_ZERO8) && !clr; // RULE6
   assign cause[`LFM_BIT_OVERTEMP]     = OVERTEMP_DET_IN;                     // RULE7
   assign cause[`LFM_BIT_LED_FAULT]    = (chan_status != `LFM_ZERO8) && !clr; // RULE5
   assign cause[`LFM_BIT_OUT_OVERVOLT] = OUT_OVERVOLT_DET_IN;
   assign cause[`LFM_BIT_THERMAL]      = THERMAL_DET_IN;
   assign cause[0] = 1'b0;

   logic [7:0] dev_status;
   assign dev_status[0] = 1'b0; // RULE3
   generate
      for (g = 1; g < 8; g++) begin : g_flag
         lfm_flag u_flag (
            .clk      (MCLK_IN),
            .rst_n    (NRST_IN),
            .set_in   (cause[g]),
            .clr_in   (clr),
            .flag_out (dev_status[g])
         );
      end
   endgenerate

   // pin source: latched flags or live causes, then mask
   wire        latched  = fault_mgmt_q[`LFM_BIT_PIN_LATCH]; // RULE23
   wire [7:0]  pin_src  = latched ? dev_status : cause; // RULE21
   wire        fault_d  = |(pin_src & ~mask_q & `LFM_STA_MASK); // RULE1 RULE2

   // read mux
   logic [7:0] rd_d;
   always_comb begin
      case (REG_ADDR_IN)
         `LFM_ADDR_PIN_MASK:     rd_d = mask_q;
         `LFM_ADDR_DEV_STATUS:   rd_d = dev_status;  // RULE3
         `LFM_ADDR_CHAN_STATUS:  rd_d = chan_status;
         `LFM_ADDR_START_STATUS: rd_d = start_sta_q; // RULE13
         `LFM_ADDR_CHAN_CONFIG:  rd_d = chan_cfg_q;
         `LFM_ADDR_FAULT_MGMT:   rd_d = fault_mgmt_q;
         `LFM_ADDR_DEV_ENABLE:   rd_d = {7'h00, dev_enable_q};
         default:                rd_d = `LFM_ZERO8;
      endcase
   end

   // sequencer: standby, one-cycle startup check, run
   always_comb begin
      case (state_q)
         lfm_pkg::LFM_ST_STBY:
            state_d = dev_enable_q ? lfm_pkg::LFM_ST_CHK : lfm_pkg::LFM_ST_STBY; // RULE16
         lfm_pkg::LFM_ST_CHK:
            state_d = lfm_pkg::LFM_ST_RUN;
         lfm_pkg::LFM_ST_RUN:
            state_d = dev_enable_q ? lfm_pkg::LFM_ST_RUN : lfm_pkg::LFM_ST_STBY;
         default:
            state_d = lfm_pkg::LFM_ST_STBY;
      endcase
   end

   // configuration registers with variant defaults
   always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         mask_q       <= VARIANT_B ? `LFM_PIN_MASK_RST_B : `LFM_PIN_MASK_RST_A; // RULE22
         chan_cfg_q   <= VARIANT_B ? `LFM_CHAN_CFG_RST_B : `LFM_CHAN_CFG_RST_A; // RULE17 RULE19
         fault_mgmt_q <= VARIANT_B ? `LFM_FAULT_MGMT_RST_B : `LFM_FAULT_MGMT_RST_A; // RULE21
         dev_enable_q <= VARIANT_B;                                             // RULE18
      end else begin
         if (wr_mask)  mask_q       <= REG_WDATA_IN & `LFM_STA_MASK;
         if (wr_ccfg)  chan_cfg_q   <= REG_WDATA_IN & `LFM_CHAN_CFG_WMASK;      // RULE10
         if (wr_fmgmt) fault_mgmt_q <= REG_WDATA_IN;
         if (wr_enab)  dev_enable_q <= REG_WDATA_IN[`LFM_BIT_DEV_ENABLE];
      end
   end

   // startup results; adjacent checks skipped when pair marked shorted
   wire [7:0] init_keep = {1'b1, ~chan_cfg_q[6:4], chan_cfg_q[3:0]}; // RULE19
   always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
      if (!NRST_IN)
         start_sta_q <= `LFM_ZERO8;
      else if (check_done)
         start_sta_q <= INIT_RESULT_IN & init_keep; // RULE14
      else if (clr)
         start_sta_q <= `LFM_ZERO8;                 // RULE15
   end

   // outputs registered
   always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         state_q <= lfm_pkg::LFM_ST_STBY;
         rdata_q <= `LFM_ZERO8;
         fault_q <= 1'b0;
         chon_q  <= 4'h0;
      end else begin
         state_q <= state_d;
         rdata_q <= REG_RD_IN ? rd_d : rdata_q;
         fault_q <= fault_d & ~clr; // RULE12 RULE15
         chon_q  <= (state_q == lfm_pkg::LFM_ST_RUN) ? (chan_cfg_q[3:0] & ~auto_off) : 4'h0; // RULE20
      end
   end

   assign REG_RDATA_OUT = rdata_q;
   assign FAULT_OUT     = fault_q;
   assign CH_ON_OUT     = chon_q;
   assign RUN_OUT       = (state_q == lfm_pkg::LFM_ST_RUN);

   // checks
   property p_mask_blocks;
      @(posedge MCLK_IN) disable iff (!NRST_IN)
      (fault_d == 1'b0) |=> !FAULT_OUT;
   endproperty
   a_mask_blocks: assert property (p_mask_blocks) else $error("pin high without cause"); // RULE1

   property p_led_fault_flag;
      @(posedge MCLK_IN) disable iff (!NRST_IN)
      (chan_status != 8'h00) && !clr |=> dev_status[`LFM_BIT_LED_FAULT];
   endproperty
   a_led_fault_flag: assert property (p_led_fault_flag) else $error("led fault flag not set"); // RULE5

   property p_sticky;
      @(posedge MCLK_IN) disable iff (!NRST_IN)
      (dev_status[`LFM_BIT_THERMAL] && !clr) |=> dev_status[`LFM_BIT_THERMAL];
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag dropped without clear"); // RULE4

   property p_clr_init;
      @(posedge MCLK_IN) disable iff (!NRST_IN)
      (clr && !check_done) |=> (start_sta_q == 8'h00);
   endproperty
   a_clr_init: assert property (p_clr_init) else $error("startup status not cleared"); // RULE15

   property p_disabled_zero;
      @(posedge MCLK_IN) disable iff (!NRST_IN)
      !chan_cfg_q[0] |=> (!short_flags[0] && !open_flags[0]);
   endproperty
   a_disabled_zero: assert property (p_disabled_zero) else $error("disabled channel flagged"); // RULE10

   property p_standby;
      @(posedge MCLK_IN) disable iff (!NRST_IN)
      !dev_enable_q && !RUN_OUT |=> !RUN_OUT;
   endproperty
   a_standby: assert property (p_standby) else $error("left standby without enable"); // RULE16

   property p_channel_check_flag;
      @(posedge MCLK_IN) disable iff (!NRST_IN)
      (start_sta_q != 8'h00) && !clr |=> dev_status[`LFM_BIT_CHAN_CHECK];
   endproperty
   a_channel_check_flag: assert property (p_channel_check_flag) else $error("check flag not set"); // RULE6

   property p_clr_pin;
      @(posedge MCLK_IN) disable iff (!NRST_IN)
      clr |=> !FAULT_OUT;
   endproperty
   a_clr_pin: assert property (p_clr_pin) else $error("pin not released on clear"); // RULE12

   c_fault: cover property (@(posedge MCLK_IN) disable iff (!NRST_IN) $rose(FAULT_OUT));
   c_run:   cover property (@(posedge MCLK_IN) disable iff (!NRST_IN) $rose(RUN_OUT));
   c_off:   cover property (@(posedge MCLK_IN) disable iff (!NRST_IN) auto_off != 4'h0);
endmodule

// File: lfm_host.sv
// Purpose: host side model driving the register port of the fault block
// Assumes: single-cycle strobes, signals changed at the falling edge
// Notes:   released address and data lines show the inverse of their last value
`include "lfm_defs.svh"
`timescale 1ns/1ps
module lfm_host (
   input  wire logic       clk_in,
   input  wire logic [7:0] rdata_in,
   output logic            wr_out,
   output logic            rd_out,
   output logic [7:0]      addr_out,
   output logic [7:0]      wdata_out
);
   // idle bus from time zero
   initial begin
      wr_out    = 1'b0;
      rd_out    = 1'b0;
      addr_out  = 8'hFF;
      wdata_out = 8'hFF;
   end
   // one write, strobe held across exactly one rising edge
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_in);
      wr_out    = 1'b1;
      addr_out  = a;
      wdata_out = d;
      @(negedge clk_in);
      wr_out    = 1'b0;
      addr_out  = ~a; // stale lines must never look valid
      wdata_out = ~d;
   endtask
   // one read, data taken one and a half cycles after the taking edge
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_in);
      rd_out   = 1'b1;
      addr_out = a;
      @(negedge clk_in);
      rd_out   = 1'b0;
      addr_out = ~a;
      @(negedge clk_in);
      d = rdata_in;
   endtask
   // leave standby only once configuration is in place
   task automatic enable_dev();
      wr_reg(`LFM_ADDR_DEV_ENABLE, 8'h01);
   endtask
endmodule

// File: lfm_top_test.sv
// Purpose: self-checking bench for the led fault status and mask block
// Assumes: host model owns the register port, detectors driven here
// Notes:   second instance shares the bus, checked for standalone defaults
`include "lfm_defs.svh"
`timescale 1ns/1ps
module lfm_top_test;
   logic       clk, nrst, ch_det, fault_a, fault_b, run_a, run_b, wr, rd;
   logic [4:0] det;
   logic [3:0] drop, noreg, on_a, on_b;
   logic [7:0] init_res, addr, wdata, rdata_a, rdata_b, v;
   int         error_cnt, check_count, cyc_cnt;
   int         pos[5] = '{1, 2, 4, 6, 7};
   lfm_host i_host (.clk_in(clk), .rdata_in(rdata_a), .wr_out(wr), .rd_out(rd),
      .addr_out(addr), .wdata_out(wdata));
   lfm_top #(.VARIANT_B(1'b0), .NCH(4)) i_dut (.MCLK_IN(clk), .NRST_IN(nrst),
      .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
      .IN_OVERCUR_DET_IN(det[4]), .IN_OVERVOLT_DET_IN(det[3]), .OVERTEMP_DET_IN(det[2]),
      .OUT_OVERVOLT_DET_IN(det[1]), .THERMAL_DET_IN(det[0]), .CH_DETECT_IN(ch_det),
      .CH_DROP_IN(drop), .CH_NOREG_IN(noreg), .INIT_RESULT_IN(init_res),
      .REG_RDATA_OUT(rdata_a), .FAULT_OUT(fault_a), .CH_ON_OUT(on_a), .RUN_OUT(run_a));
   lfm_top #(.VARIANT_B(1'b1), .NCH(4)) i_dut_b (.MCLK_IN(clk), .NRST_IN(nrst),
      .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
      .IN_OVERCUR_DET_IN(det[4]), .IN_OVERVOLT_DET_IN(det[3]), .OVERTEMP_DET_IN(det[2]),
      .OUT_OVERVOLT_DET_IN(det[1]), .THERMAL_DET_IN(det[0]), .CH_DETECT_IN(ch_det),
      .CH_DROP_IN(drop), .CH_NOREG_IN(noreg), .INIT_RESULT_IN(init_res),
      .REG_RDATA_OUT(rdata_b), .FAULT_OUT(fault_b), .CH_ON_OUT(on_b), .RUN_OUT(run_b));
   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // hang guard, the whole sequence needs well under a thousand cycles
   always @(posedge clk) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 5000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      i_host.rd_reg(a, v);
      chk(v, e);
   endtask
   // both instances answer the same read on their own data ports
   task automatic rdb(input logic [7:0] a, input logic [7:0] ea, input logic [7:0] eb);
      rdc(a, ea);
      chk(rdata_b, eb);
   endtask
   task automatic clear();
      i_host.wr_reg(`LFM_ADDR_DEV_CONFIG, 8'h01);
      repeat (2) @(negedge clk);
   endtask
   task automatic pulse_detect();
      @(negedge clk);
      ch_det = 1'b1;
      @(negedge clk);
      ch_det = 1'b0;
      repeat (3) @(negedge clk);
   endtask
   // main sequence, inputs change only at falling edges
   initial begin
      nrst = 1'b0;
      cyc_cnt = 0;
      {ch_det, det, drop, noreg} = 14'h0000;
      init_res = 8'h00;
      repeat (2) @(negedge clk);
      nrst = 1'b1;
      rdb(`LFM_ADDR_PIN_MASK, 8'h00, 8'h10);
      rdb(`LFM_ADDR_CHAN_CONFIG, 8'h0F, 8'h7F);
      rdb(`LFM_ADDR_FAULT_MGMT, 8'h01, 8'h69);
      rdb(`LFM_ADDR_DEV_STATUS, 8'h00, 8'h00);
      rdb(`LFM_ADDR_CHAN_STATUS, 8'h00, 8'h00);
      rdb(`LFM_ADDR_START_STATUS, 8'h00, 8'h00);
      rdb(8'h30, 8'h00, 8'h00);
      chk({6'h00, run_a, run_b}, 8'h01);
      i_host.wr_reg(`LFM_ADDR_DEV_STATUS, 8'hFE);
      rdc(`LFM_ADDR_DEV_STATUS, 8'h00);
      // startup check with a resistor fault and a ground short
      init_res = 8'h81;
      i_host.enable_dev();
      repeat (4) @(negedge clk);
      init_res = 8'h00;
      chk({7'h00, run_a}, 8'h01);
      rdc(`LFM_ADDR_START_STATUS, 8'h81);
      rdc(`LFM_ADDR_DEV_STATUS, 8'h20);
      chk({7'h00, fault_a}, 8'h01);
      i_host.wr_reg(`LFM_ADDR_PIN_MASK, 8'h20);
      repeat (3) @(negedge clk);
      chk({7'h00, fault_a}, 8'h00);
      rdc(`LFM_ADDR_PIN_MASK, 8'h20);
      i_host.wr_reg(`LFM_ADDR_PIN_MASK, 8'h00);
      clear();
      rdc(`LFM_ADDR_START_STATUS, 8'h00);
      rdc(`LFM_ADDR_DEV_STATUS, 8'h00);
      rdc(`LFM_ADDR_DEV_CONFIG, 8'h00);
      chk({7'h00, fault_a}, 8'h00);
      // each detector: pin follows it live, status bit stays latched
      for (int i = 0; i < 5; i++) begin
         det[i] = 1'b1;
         repeat (3) @(negedge clk);
         chk({7'h00, fault_a}, 8'h01);
         det[i] = 1'b0;
         repeat (3) @(negedge clk);
         chk({6'h00, fault_a, fault_b}, 8'h00);
         rdc(`LFM_ADDR_DEV_STATUS, 8'h01 << pos[i]);
         clear();
         rdc(`LFM_ADDR_DEV_STATUS, 8'h00);
      end
      // latched pin outlives its cause until masked or cleared
      i_host.wr_reg(`LFM_ADDR_FAULT_MGMT, 8'h11);
      det[0] = 1'b1;
      repeat (2) @(negedge clk);
      det[0] = 1'b0;
      repeat (3) @(negedge clk);
      chk({7'h00, fault_a}, 8'h01);
      i_host.wr_reg(`LFM_ADDR_PIN_MASK, 8'h02);
      repeat (2) @(negedge clk);
      chk({7'h00, fault_a}, 8'h00);
      clear();
      i_host.wr_reg(`LFM_ADDR_PIN_MASK, 8'h00);
      repeat (2) @(negedge clk);
      chk({7'h00, fault_a}, 8'h00);
      i_host.wr_reg(`LFM_ADDR_FAULT_MGMT, 8'h01);
      // channel short on ch1, open on ch3
      drop  = 4'h1;
      noreg = 4'h4;
      pulse_detect();
      rdc(`LFM_ADDR_CHAN_STATUS, 8'h14);
      rdc(`LFM_ADDR_DEV_STATUS, 8'h08);
      chk({7'h00, fault_a}, 8'h01);
      chk({4'h0, on_a}, 8'h0F);
      i_host.wr_reg(`LFM_ADDR_CHAN_CONFIG, 8'h0E);
      pulse_detect();
      rdc(`LFM_ADDR_CHAN_STATUS, 8'h04);
      rdc(`LFM_ADDR_CHAN_CONFIG, 8'h0E);
      i_host.wr_reg(`LFM_ADDR_FAULT_MGMT, 8'h09);
      pulse_detect();
      chk({4'h0, on_a}, 8'h0A);
      {drop, noreg} = 8'h00;
      clear();
      rdc(`LFM_ADDR_CHAN_STATUS, 8'h00);
      rdc(`LFM_ADDR_DEV_STATUS, 8'h00);
      chk({7'h00, fault_a}, 8'h00);
      tally_and_finish();
   end
endmodule
